// >>> core/scb_sysref_cal_defs.svh
// constants of the reference-pulse calibration register bank
// assumes byte-wide register access on the sampling clock
`ifndef SCB_SYSREF_CAL_DEFS_SVH
`define SCB_SYSREF_CAL_DEFS_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define SCB_ADDR_CFG        12'h2B1
`define SCB_ADDR_STAT0      12'h2B2
`define SCB_ADDR_STAT1      12'h2B3
`define SCB_ADDR_STAT2      12'h2B4
`define SCB_ADDR_MAN0       12'h2B5
`define SCB_ADDR_MAN1       12'h2B6
`define SCB_ADDR_MAN2       12'h2B7

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define SCB_CFG_HDUR_LSB    2'h0
`define SCB_CFG_AVG_LSB     2'h2
`define SCB_CFG_RESET       4'h5
`define SCB_STAT_DONE_BIT   5'h11
`define SCB_MAN_RESET       17'h00000

// ----------------------------------------------------------------------
// timing counts, in sampling-clock cycles
// ----------------------------------------------------------------------
`define SCB_CAL_STEP_CYCLES 32'h00004C00
`define SCB_PERIOD_MAX_0    16'h0055
`define SCB_PERIOD_MAX_1    16'h044C
`define SCB_PERIOD_MAX_2    16'h1450
`define SCB_PERIOD_MAX_3    16'h544C

`endif

// >>> core/scb_pkg.sv
// types and shared decoders of the reference-pulse calibration bank
// assumes the constants header is on the include path
`include "scb_sysref_cal_defs.svh"

package scb_pkg;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       invert;     // sampling clock inverted
		logic [7:0] coarse;     // coarse delay setting
		logic [7:0] fine;       // fine delay setting
	} scb_delay_t;

	typedef struct packed {
		logic [1:0] avg;        // averaging code
		logic [1:0] hdur;       // accumulation-length code
	} scb_cfg_t;

	typedef enum logic [1:0] {
		SCB_IDLE,
		SCB_RUN,
		SCB_DONE,
		SCB_FAIL
	} scb_state_t;

	// ------------------------------------------------------------------
	// decoders
	// ------------------------------------------------------------------
	// code 0..3 gives 4, 16, 64, 256
	function automatic logic [8:0] scb_count_sel(input logic [1:0] code);
		logic [8:0] r;
		r = 9'h004 << {code, 1'b0};
		return r;
	endfunction

	// longest supported reference period per accumulation-length code
	function automatic logic [15:0] scb_period_max(input logic [1:0] code);
		logic [15:0] r;
		unique case (code)
			2'h0: r = `SCB_PERIOD_MAX_0;
			2'h1: r = `SCB_PERIOD_MAX_1;
			2'h2: r = `SCB_PERIOD_MAX_2;
			2'h3: r = `SCB_PERIOD_MAX_3;
		endcase
		return r;
	endfunction

endpackage

// >>> core/scb_period_mon.sv
// reference pulse period monitor
// assumes the pulse pin is asynchronous to core_clk
`timescale 1ns/10ps
`include "scb_sysref_cal_defs.svh"

module scb_period_mon (
	input  wire logic       core_clk,    // sampling clock
	input  wire logic       nrst,        // async reset, active low
	input  wire logic       sysref_pin,  // reference pulse pin
	input  wire logic       arm,         // restart measurement
	input  wire logic [1:0] hdur_code,   // accumulation-length code
	output logic            over_q       // period beyond supported limit
);

	// ------------------------------------------------------------------
	// synchroniser and edge detect
	// ------------------------------------------------------------------
	logic        sync1_q;
	logic        sync2_q;
	logic        sync3_q;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic        rise_w;
	logic        sat_w;
	logic [15:0] limit_w;

	// two flops before any logic reads the pin
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
		end else begin
			sync1_q <= sysref_pin;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// ------------------------------------------------------------------
	// interval counter
	// ------------------------------------------------------------------
	assign rise_w  = sync2_q & ~sync3_q;
	assign sat_w   = &cnt_q;
	assign limit_w = scb_pkg::scb_period_max(hdur_code);
	assign cnt_d   = (arm | rise_w) ? 16'h0000 : (sat_w ? cnt_q : cnt_q + 16'h0001);

	// count cycles since the last edge; flag an overlong interval
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q  <= 16'h0000;
			over_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			over_q <= arm ? 1'b0 : (over_q | (cnt_q > limit_w));
		end
	end

endmodule // scb_period_mon

// >>> core/scb_sysref_cal.sv
// configuration, status and manual delay registers of the
// reference-pulse timing calibration, with its run sequencer
// assumes byte register port, enable bit and measurement engine
// all on core_clk; the reference pulse pin is asynchronous
`timescale 1ns/10ps
`include "scb_sysref_cal_defs.svh"

// Function
// - averaging code selects 4/16/64/256 accumulations
// - length code selects 4/16/64/256 cycles
// - overlong reference period makes calibration fail
// - calibration ends within bounded cycle count
// - configuration resets 0x05, upper nibble reserved
// - done reads one only enabled and complete
// - result valid only while done reads one
// - status is 24-bit read-only at 0x2B2
// - manual delay spans 0x2B5-0x2B7, resets zero
// - enable rise starts; manual ignored while enabled
// - disabled: manual register drives aperture delay
module scb_sysref_cal #(
	parameter int unsigned CAL_STEP_CYCLES = `SCB_CAL_STEP_CYCLES
) (
	input  wire logic              core_clk,          // sampling clock
	input  wire logic              nrst,              // async reset, active low
	input  wire logic [11:0]       reg_addr,          // register byte address
	input  wire logic [7:0]        reg_wdata,         // write byte
	input  wire logic              reg_wr,            // write strobe
	input  wire logic              reg_rd,            // read strobe
	output logic [7:0]             reg_rdata_q,       // read byte, next cycle
	input  wire logic              cal_enable,        // calibration enable bit
	input  wire logic              sysref_pin,        // reference pulse pin
	input  wire logic              eng_done,          // engine finished, pulse
	input  wire scb_pkg::scb_delay_t eng_result,      // engine delay result
	output logic                   cal_start_q,       // engine start, pulse
	output logic                   cal_busy_q,        // sequence running
	output logic                   cal_fail_q,        // sequence failed
	output logic [8:0]             cal_avg_count_q,   // accumulations per measure
	output logic [8:0]             cal_accum_cycles_q, // cycles per accumulation
	output scb_pkg::scb_delay_t    aperture_delay_q   // applied aperture delay
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	scb_pkg::scb_cfg_t   cal_config_reg_q;
	scb_pkg::scb_delay_t manual_aperture_delay_q;
	scb_pkg::scb_delay_t cal_delay_result_q;
	scb_pkg::scb_state_t state_q;
	scb_pkg::scb_state_t state_d;
	logic                en_q;
	logic [17:0]         timer_q;
	logic [17:0]         timer_d;
	scb_pkg::scb_delay_t delay_d;

	// bound of one run for the current configuration
	function automatic logic [17:0] cal_bound(input scb_pkg::scb_cfg_t c);
		logic [3:0] s;
		// four bits: codes 3 and 3 plus 2 give 8, which three bits would wrap to 0
		s = {2'b00, c.avg} + {2'b00, c.hdur} + 4'h2;
		return 18'(CAL_STEP_CYCLES * s);
	endfunction

	// ------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------
	logic        en_rise_w;
	logic        over_w;
	logic        cal_complete_flag;
	logic [23:0] cal_status_reg;
	logic [23:0] man_word_w;
	logic [7:0]  rd_mux_w;
	logic        wr_cfg_w;
	logic        wr_man0_w;
	logic        wr_man1_w;
	logic        wr_man2_w;
	logic        run_w;

	assign en_rise_w = cal_enable & ~en_q;
	assign run_w     = (state_q == scb_pkg::SCB_RUN);
	// done only while enabled and the sequence completed
	assign cal_complete_flag = (state_q == scb_pkg::SCB_DONE) & cal_enable;
	// result hidden unless done; reserved bits zero
	assign cal_status_reg = {6'h00, cal_complete_flag,
		cal_complete_flag ? cal_delay_result_q : 17'h00000};
	assign man_word_w = {7'h00, manual_aperture_delay_q};

	// write strobes; status bytes take no write
	assign wr_cfg_w  = reg_wr & (reg_addr == `SCB_ADDR_CFG);
	assign wr_man0_w = reg_wr & (reg_addr == `SCB_ADDR_MAN0);
	assign wr_man1_w = reg_wr & (reg_addr == `SCB_ADDR_MAN1);
	assign wr_man2_w = reg_wr & (reg_addr == `SCB_ADDR_MAN2);

	// read selection, unmapped addresses read zero
	assign rd_mux_w =
		(reg_addr == `SCB_ADDR_CFG)   ? {4'h0, cal_config_reg_q} :
		(reg_addr == `SCB_ADDR_STAT0) ? cal_status_reg[7:0]   :
		(reg_addr == `SCB_ADDR_STAT1) ? cal_status_reg[15:8]  :
		(reg_addr == `SCB_ADDR_STAT2) ? cal_status_reg[23:16] :
		(reg_addr == `SCB_ADDR_MAN0)  ? man_word_w[7:0]       :
		(reg_addr == `SCB_ADDR_MAN1)  ? man_word_w[15:8]      :
		(reg_addr == `SCB_ADDR_MAN2)  ? man_word_w[23:16]     : 8'h00;

	// ------------------------------------------------------------------
	// period monitor
	// ------------------------------------------------------------------
	scb_period_mon u_period_mon (
		.core_clk  (core_clk),
		.nrst      (nrst),
		.sysref_pin(sysref_pin),
		.arm       (en_rise_w),
		.hdur_code (cal_config_reg_q.hdur),
		.over_q    (over_w)
	);

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	// engine completion wins over failure in the same cycle
	always_comb begin
		state_d = state_q;
		timer_d = timer_q;
		if (!cal_enable) begin
			state_d = scb_pkg::SCB_IDLE;
		end else if (en_rise_w) begin
			state_d = scb_pkg::SCB_RUN;
			timer_d = cal_bound(cal_config_reg_q) - 18'h00001;
		end else begin
			unique case (state_q)
				scb_pkg::SCB_RUN: begin
					if (eng_done) begin
						state_d = scb_pkg::SCB_DONE;
					end else if (over_w) begin
						state_d = scb_pkg::SCB_FAIL;
					end else if (timer_q == 18'h00000) begin
						state_d = scb_pkg::SCB_FAIL;
					end else begin
						timer_d = timer_q - 18'h00001;
					end
				end
				scb_pkg::SCB_IDLE: state_d = state_q;
				scb_pkg::SCB_DONE: state_d = state_q;
				scb_pkg::SCB_FAIL: state_d = state_q;
			endcase
		end
	end

	// applied delay: manual when disabled, result once done
	assign delay_d = !cal_enable ? manual_aperture_delay_q :
		(state_q == scb_pkg::SCB_DONE) ? cal_delay_result_q : aperture_delay_q;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= scb_pkg::SCB_IDLE;
			en_q    <= 1'b0;
			timer_q <= 18'h00000;
		end else begin
			state_q <= state_d;
			en_q    <= cal_enable;
			timer_q <= timer_d;
		end
	end

	// capture of the engine result with its three fields
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cal_delay_result_q <= 17'h00000;
		end else if (run_w & eng_done & cal_enable & ~en_rise_w) begin
			cal_delay_result_q <= eng_result;
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	// configuration and manual delay, reserved bits dropped
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cal_config_reg_q        <= `SCB_CFG_RESET;
			manual_aperture_delay_q <= `SCB_MAN_RESET;
		end else begin
			if (wr_cfg_w) cal_config_reg_q <= reg_wdata[3:0];
			if (wr_man0_w) manual_aperture_delay_q.fine <= reg_wdata;
			if (wr_man1_w) manual_aperture_delay_q.coarse <= reg_wdata;
			if (wr_man2_w) manual_aperture_delay_q.invert <= reg_wdata[0];
		end
	end

	// registered outputs
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata_q        <= 8'h00;
			cal_start_q        <= 1'b0;
			cal_busy_q         <= 1'b0;
			cal_fail_q         <= 1'b0;
			cal_avg_count_q    <= 9'h010;
			cal_accum_cycles_q <= 9'h010;
			aperture_delay_q   <= 17'h00000;
		end else begin
			if (reg_rd) reg_rdata_q <= rd_mux_w;
			cal_start_q        <= en_rise_w;
			cal_busy_q         <= (state_d == scb_pkg::SCB_RUN);
			cal_fail_q         <= (state_d == scb_pkg::SCB_FAIL);
			cal_avg_count_q    <= scb_pkg::scb_count_sel(cal_config_reg_q.avg);
			cal_accum_cycles_q <= scb_pkg::scb_count_sel(cal_config_reg_q.hdur);
			aperture_delay_q   <= delay_d;
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	// age of the current run and the bound it started with
	logic [17:0] chk_age_q;
	logic [17:0] chk_lim_q;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			chk_age_q <= 18'h00000;
			chk_lim_q <= 18'h00000;
		end else begin
			chk_age_q <= en_rise_w ? 18'h00000 : (run_w ? chk_age_q + 18'h00001 : chk_age_q);
			if (en_rise_w) chk_lim_q <= cal_bound(cal_config_reg_q);
		end
	end

	property p_start_on_rise;
		@(posedge core_clk) disable iff (!nrst)
		(cal_enable && !en_q) |=> (cal_start_q && cal_busy_q && run_w);
	endproperty
	a_start_on_rise: assert property (p_start_on_rise)
		else $error("no start after enable rise");

	property p_done_clear_at_start;
		@(posedge core_clk) disable iff (!nrst)
		cal_start_q |-> !cal_complete_flag ##1 (!cal_complete_flag || !run_w);
	endproperty
	a_done_clear_at_start: assert property (p_done_clear_at_start)
		else $error("done flag set at start");

	property p_done_needs_enable;
		@(posedge core_clk) disable iff (!nrst)
		!cal_enable |-> !cal_complete_flag;
	endproperty
	a_done_needs_enable: assert property (p_done_needs_enable)
		else $error("done set while disabled");

	property p_done_read_disabled;
		@(posedge core_clk) disable iff (!nrst)
		(reg_rd && reg_addr == `SCB_ADDR_STAT2 && !cal_enable) |=> (reg_rdata_q[1] == 1'b0);
	endproperty
	a_done_read_disabled: assert property (p_done_read_disabled)
		else $error("done bit read high while disabled");

	property p_manual_drives;
		@(posedge core_clk) disable iff (!nrst)
		!cal_enable |=> (aperture_delay_q == $past(manual_aperture_delay_q));
	endproperty
	a_manual_drives: assert property (p_manual_drives)
		else $error("manual delay not applied");

	property p_run_bounded;
		@(posedge core_clk) disable iff (!nrst)
		run_w |-> (chk_age_q < chk_lim_q);
	endproperty
	a_run_bounded: assert property (p_run_bounded)
		else $error("calibration ran past bound");

	property p_over_fails;
		@(posedge core_clk) disable iff (!nrst)
		(run_w && cal_enable && !en_rise_w && !eng_done && over_w) |=> cal_fail_q;
	endproperty
	a_over_fails: assert property (p_over_fails)
		else $error("overlong period did not fail");

	property p_result_hidden;
		@(posedge core_clk) disable iff (!nrst)
		(reg_rd && reg_addr == `SCB_ADDR_STAT2 && !cal_complete_flag) |=> (reg_rdata_q == 8'h00);
	endproperty
	a_result_hidden: assert property (p_result_hidden)
		else $error("status shows data while not done");

	property p_cfg_reserved;
		@(posedge core_clk) disable iff (!nrst)
		(reg_rd && reg_addr == `SCB_ADDR_CFG) |=> (reg_rdata_q[7:4] == 4'h0);
	endproperty
	a_cfg_reserved: assert property (p_cfg_reserved)
		else $error("reserved configuration bits nonzero");

	property p_result_capture;
		@(posedge core_clk) disable iff (!nrst)
		(run_w && eng_done && cal_enable && !en_rise_w) |=> ##1
			(aperture_delay_q == $past(eng_result, 2) || !cal_enable);
	endproperty
	a_result_capture: assert property (p_result_capture)
		else $error("result not applied after done");

	property p_avg_decode;
		@(posedge core_clk) disable iff (!nrst)
		(wr_cfg_w && reg_wdata[3:2] == 2'h3) |=> ##1 (cal_avg_count_q == 9'h100);
	endproperty
	a_avg_decode: assert property (p_avg_decode)
		else $error("averaging count wrong");

	property p_man_write;
		@(posedge core_clk) disable iff (!nrst)
		wr_man1_w |=> (manual_aperture_delay_q.coarse == $past(reg_wdata));
	endproperty
	a_man_write: assert property (p_man_write)
		else $error("manual coarse byte not written");

	c_done: cover property (@(posedge core_clk) disable iff (!nrst)
		run_w ##1 cal_complete_flag);
	c_fail: cover property (@(posedge core_clk) disable iff (!nrst)
		run_w ##1 cal_fail_q);
	c_restart: cover property (@(posedge core_clk) disable iff (!nrst)
		cal_complete_flag ##[1:20] cal_start_q);

endmodule // scb_sysref_cal

// >>> dv/tb_sysref_cal_config_status.sv
// self-checking bench of the reference-pulse calibration register bank
// assumes the package and constants header compiled first, design on core_clk
`timescale 1ns/10ps
`include "scb_sysref_cal_defs.svh"

module tb_sysref_cal_config_status;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	localparam int unsigned STEP = 64;  // shortened step; hdur 0 limit 85 beats timeout
	typedef struct {
		logic [7:0] wdata;
		logic [7:0] rd;
		logic [8:0] avg;
		logic [8:0] acc;
	} scb_tb_row_t;
	logic                core_clk;
	logic                nrst;
	logic [11:0]         reg_addr;
	logic [7:0]          reg_wdata;
	logic                reg_wr;
	logic                reg_rd;
	logic [7:0]          reg_rdata_q;
	logic                cal_enable;
	logic                sysref_pin;
	logic                pulse_on;
	logic                eng_done;
	scb_pkg::scb_delay_t eng_result;
	scb_pkg::scb_delay_t aperture_delay_q;
	logic                cal_start_q;
	logic                cal_busy_q;
	logic                cal_fail_q;
	logic [8:0]          cal_avg_count_q;
	logic [8:0]          cal_accum_cycles_q;
	logic [7:0]          rb;
	int                  failures;
	int                  total_checks;
	int                  n;
	scb_tb_row_t         rows [5];

	scb_sysref_cal #(.CAL_STEP_CYCLES(STEP)) DUT (
		.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.cal_enable(cal_enable), .sysref_pin(sysref_pin), .eng_done(eng_done),
		.eng_result(eng_result), .cal_start_q(cal_start_q), .cal_busy_q(cal_busy_q),
		.cal_fail_q(cal_fail_q), .cal_avg_count_q(cal_avg_count_q),
		.cal_accum_cycles_q(cal_accum_cycles_q), .aperture_delay_q(aperture_delay_q)
	);

	// ------------------------------------------------------------------
	// clock, reference pulses every 40 cycles when allowed, watchdog
	// ------------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	always begin
		sysref_pin = 1'b0;
		repeat (39) @(negedge core_clk);
		sysref_pin = pulse_on;
		@(negedge core_clk);
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		close_out();
	end

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one write strobe, released after its edge
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask

	// read strobe, data taken once the answer edge has passed
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		@(negedge core_clk);
		d = reg_rdata_q;
	endtask

	task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(what, {16'h0000, d}, {16'h0000, exp});
	endtask

	// bounded wait for the fail level, cycles counted from entry
	task automatic wait_fail(input int bound, output int cnt);
		cnt = 0;
		while (cal_fail_q !== 1'b1 && cnt < bound) begin
			@(negedge core_clk);
			cnt++;
		end
		if (cal_fail_q !== 1'b1) begin
			failures++;
			$display("mismatch fail wait expected 1 seen %b", cal_fail_q);
			close_out();
		end
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		{nrst, reg_wr, reg_rd, cal_enable, pulse_on, eng_done} = 6'h00;
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		eng_result = 17'h00000;
		failures = 0;
		total_checks = 0;
		rows[0] = '{8'hF0, 8'h00, 9'h004, 9'h004};
		rows[1] = '{8'h05, 8'h05, 9'h010, 9'h010};
		rows[2] = '{8'h0A, 8'h0A, 9'h040, 9'h040};
		rows[3] = '{8'hFF, 8'h0F, 9'h100, 9'h100};
		rows[4] = '{8'h06, 8'h06, 9'h010, 9'h040};
		repeat (12) @(negedge core_clk);
		nrst = 1'b1;
		// reset values
		rd_chk("cfg reset", `SCB_ADDR_CFG, 8'h05);
		rd_chk("man0 reset", `SCB_ADDR_MAN0, 8'h00);
		rd_chk("man1 reset", `SCB_ADDR_MAN1, 8'h00);
		rd_chk("man2 reset", `SCB_ADDR_MAN2, 8'h00);
		chk("avg count reset", {15'h0000, cal_avg_count_q}, 24'h000010);
		chk("accum reset", {15'h0000, cal_accum_cycles_q}, 24'h000010);
		chk("delay reset", {7'h00, aperture_delay_q}, 24'h000000);
		rd_chk("done disabled", `SCB_ADDR_STAT2, 8'h00);
		// configuration codes, reserved nibble included
		foreach (rows[i]) begin
			wr(`SCB_ADDR_CFG, rows[i].wdata);
			repeat (3) @(negedge core_clk);
			rd_chk("cfg readback", `SCB_ADDR_CFG, rows[i].rd);
			chk("avg count", {15'h0000, cal_avg_count_q}, {15'h0000, rows[i].avg});
			chk("accum", {15'h0000, cal_accum_cycles_q}, {15'h0000, rows[i].acc});
		end
		// manual delay drives the aperture while disabled
		wr(`SCB_ADDR_MAN0, 8'h3C);
		wr(`SCB_ADDR_MAN1, 8'hA5);
		wr(`SCB_ADDR_MAN2, 8'hFF);
		rd_chk("man2 reserved", `SCB_ADDR_MAN2, 8'h01);
		rd_chk("man1", `SCB_ADDR_MAN1, 8'hA5);
		chk("manual delay", {7'h00, aperture_delay_q}, 24'h01A53C);
		// read-only status and unmapped space
		wr(`SCB_ADDR_STAT0, 8'hFF);
		rd_chk("status write", `SCB_ADDR_STAT0, 8'h00);
		rd_chk("unmapped", 12'h300, 8'h00);
		// successful calibration, avg 1 hdur 0
		wr(`SCB_ADDR_CFG, 8'h04);
		pulse_on = 1'b1;
		@(negedge core_clk);
		cal_enable = 1'b1;
		n = 0;
		while (cal_start_q !== 1'b1 && n < 4) begin
			@(negedge core_clk);
			n++;
		end
		chk("start pulse", {23'h000000, cal_start_q}, 24'h000001);
		chk("busy", {23'h000000, cal_busy_q}, 24'h000001);
		@(negedge core_clk);
		chk("start single", {23'h000000, cal_start_q}, 24'h000000);
		wr(`SCB_ADDR_MAN1, 8'h00);
		repeat (3) @(negedge core_clk);
		chk("manual ignored", {7'h00, aperture_delay_q}, 24'h01A53C);
		rd_chk("done while running", `SCB_ADDR_STAT2, 8'h00);
		eng_result = 17'h15AC3;
		eng_done = 1'b1;
		@(negedge core_clk);
		eng_done = 1'b0;
		repeat (2) @(negedge core_clk);
		chk("busy after done", {23'h000000, cal_busy_q}, 24'h000000);
		rd_chk("status hi", `SCB_ADDR_STAT2, 8'h03);
		rd_chk("status coarse", `SCB_ADDR_STAT1, 8'h5A);
		rd_chk("status fine", `SCB_ADDR_STAT0, 8'hC3);
		chk("applied result", {7'h00, aperture_delay_q}, 24'h015AC3);
		chk("no fail", {23'h000000, cal_fail_q}, 24'h000000);
		cal_enable = 1'b0;
		repeat (2) @(negedge core_clk);
		rd_chk("done after disable", `SCB_ADDR_STAT2, 8'h00);
		chk("manual back", {7'h00, aperture_delay_q}, 24'h01003C);
		// copy the result into the manual register
		wr(`SCB_ADDR_MAN0, 8'hC3);
		wr(`SCB_ADDR_MAN1, 8'h5A);
		wr(`SCB_ADDR_MAN2, 8'h01);
		repeat (3) @(negedge core_clk);
		chk("copied result", {7'h00, aperture_delay_q}, 24'h015AC3);
		// no reference pulses: period limit 85 trips before timeout 128
		wr(`SCB_ADDR_CFG, 8'h00);
		pulse_on = 1'b0;
		@(negedge core_clk);
		cal_enable = 1'b1;
		wait_fail(125, n);
		chk("period fail time", 24'(n >= 85 && n <= 95), 24'h000001);
		eng_done = 1'b1;
		@(negedge core_clk);
		eng_done = 1'b0;
		repeat (2) @(negedge core_clk);
		rd_chk("done after fail", `SCB_ADDR_STAT2, 8'h00);
		cal_enable = 1'b0;
		repeat (2) @(negedge core_clk);
		// pulses present, no engine answer: timeout at 64*3 cycles
		pulse_on = 1'b1;
		wr(`SCB_ADDR_CFG, 8'h04);
		cal_enable = 1'b1;
		wait_fail(260, n);
		chk("timeout time", 24'(n >= 180 && n <= 198), 24'h000001);
		cal_enable = 1'b0;
		// reset in mid-run
		wr(`SCB_ADDR_CFG, 8'h0F);
		cal_enable = 1'b1;
		repeat (5) @(negedge core_clk);
		nrst = 1'b0;
		cal_enable = 1'b0;
		repeat (2) @(negedge core_clk);
		nrst = 1'b1;
		chk("busy after reset", {23'h000000, cal_busy_q}, 24'h000000);
		rd_chk("cfg after reset", `SCB_ADDR_CFG, 8'h05);
		close_out();
	end
endmodule // tb_sysref_cal_config_status
